//--- rtl/dpa_cfg.svh
// Register map, field positions, reset values and timing counts of the port allocator
`ifndef DPA_CFG_SVH
`define DPA_CFG_SVH
// ==========================================================
// Register offsets
`define DPA_NET_CTRL      8'h00
`define DPA_NET_STAT      8'h04
`define DPA_APPLY         8'h08
`define DPA_PORT_CTRL0    8'h10
`define DPA_PORT_STAT0    8'h20
`define DPA_PORT_BW0      8'h30
// ==========================================================
// Field positions
`define DPA_RESTORE_BIT   8
`define DPA_TR_IDLE_BIT   1
`define DPA_CNT_LSB       16
`define DPA_CNT_MSB       25
`define DPA_REJECT_BIT    16
`define DPA_COARSE_BIT    4
// ==========================================================
// Reset values
`define DPA_NET_DEF       8'h04
`define DPA_CNT_DEF       10'h001
// ==========================================================
// Block pools, per-port limits and block rates in bit/s
`define DPA_FINE_POOL     10'd588
`define DPA_COARSE_POOL   10'd14
`define DPA_HSSI_MAX      10'd588
`define DPA_V35_MAX       10'd140
`define DPA_FINE_BPS      32'd75184
`define DPA_COARSE_BPS    32'd3160000
// ==========================================================
// Timing
`define DPA_CLK_PERIOD_NS 5
`define DPA_RESTART_NS    1000
`define DPA_RESTART_CYC   ((`DPA_RESTART_NS + `DPA_CLK_PERIOD_NS - 1) / `DPA_CLK_PERIOD_NS)
`define DPA_LOSS_NS       1000
`define DPA_LOSS_CYC      (`DPA_LOSS_NS / `DPA_CLK_PERIOD_NS)
`endif

//--- rtl/dpa_pkg.sv
// Types shared by the port allocator
package dpa_pkg;
    // ==========================================================
    // Line configuration
    typedef enum logic [1:0] {
        FR_CBIT = 2'h0,
        FR_M13  = 2'h1,
        FR_AUTO = 2'h2
    } dpa_framing_type;
    typedef enum logic [1:0] {
        AC_OFF    = 2'h0,
        AC_MASTER = 2'h1,
        AC_SLAVE  = 2'h2
    } dpa_role_type;
    typedef struct packed {
        dpa_role_type    role;
        logic            data_link;
        logic            coarse;
        logic            scramble;
        logic            loop_timing;
        dpa_framing_type framing;
    } dpa_net_cfg_type;
    // ==========================================================
    // Port configuration and status, block allocation and restart state
    typedef struct packed {
        logic [9:0] bandwidth_block_count;
        logic       tr_idle;
        logic       enable;
    } dpa_port_cfg_type;
    typedef enum logic [2:0] {
        PS_ABSENT   = 3'h0,
        PS_INACTIVE = 3'h1,
        PS_WAITING  = 3'h3,
        PS_ACTIVE   = 3'h2,
        PS_ERROR    = 3'h6
    } dpa_port_status_type;
    typedef struct packed {
        logic [3:0][9:0] blocks;
    } dpa_alloc_type;
    typedef enum logic {
        RS_RUN  = 1'b0,
        RS_BOOT = 1'b1
    } dpa_restart_type;
endpackage

//--- rtl/dpa_allocator.sv
// Line options, bandwidth block allocation and DTE port status with APB register access
`timescale 1ns/1ps
`include "dpa_cfg.svh"
module dpa_allocator
    import dpa_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Line side
    input  wire logic              rx_m13_seen,
    input  wire logic              payload_bit,
    input  wire logic              payload_valid,
    output logic                   line_bit_q,
    output logic                   line_bit_valid_q,
    output logic                   tx_loop_timing_q,
    output logic                   framing_m13_q,
    // Management channel
    input  wire logic              mgmt_tx_bit,
    output logic                   dl_enable_q,
    output logic                   dl_tx_bit_q,
    // Remote allocation exchange
    input  wire logic              alloc_rx_valid,
    input  dpa_alloc_type          alloc_rx,
    output logic                   alloc_tx_valid_q,
    output dpa_alloc_type          alloc_tx_q,
    // DTE ports
    input  wire logic [3:0]        port_installed,
    input  wire logic [3:0]        port_is_hssi,
    input  wire logic [3:0]        terminal_ready_lead,
    input  wire logic [3:0]        dte_tx_clk,
    output logic      [3:0]        port_pass_q,
    output dpa_alloc_type          applied_q,
    output logic                   restart_q
);
    // ==========================================================
    // Parameter check
    if (ADDR_W < 6) begin : g_bad_addr
        $error("ADDR_W too small for the register map");
    end

    // ==========================================================
    // Pin synchronisers and DTE clock loss detection
    logic [3:0]          inst_s, hssi_s, lead_s, clk_s, clk_old, clk_lost;
    logic                m13_m, m13_s;
    logic [3:0][7:0]     loss_cnt_q;
    genvar p;
    for (p = 0; p < 4; p++) begin : g_port_sync
        logic [3:0] meta_q;
        always_ff @(posedge ref_clk) begin
            meta_q  <= {port_installed[p], port_is_hssi[p], terminal_ready_lead[p], dte_tx_clk[p]};
            inst_s[p] <= meta_q[3];
            hssi_s[p] <= meta_q[2];
            lead_s[p] <= meta_q[1];
            clk_s[p]  <= meta_q[0];
            clk_old[p] <= clk_s[p];
        end
        // A frozen clock either high or low counts as lost
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                loss_cnt_q[p] <= 8'h00;
            end else if (clk_s[p] != clk_old[p]) begin
                loss_cnt_q[p] <= 8'h00;
            end else if (!clk_lost[p]) begin
                loss_cnt_q[p] <= loss_cnt_q[p] + 8'h01;
            end
        end
        assign clk_lost[p] = (loss_cnt_q[p] >= 8'(`DPA_LOSS_CYC));
    end
    always_ff @(posedge ref_clk) begin
        m13_m <= rx_m13_seen;
        m13_s <= m13_m;
    end

    // ==========================================================
    // APB decode
    dpa_net_cfg_type          net_q;
    dpa_port_cfg_type [3:0]   pcfg_q;
    dpa_port_status_type [3:0] stat_q;
    dpa_restart_type          rs_q;
    logic [7:0]               rs_cnt_q;
    logic                     reject_q;
    logic [9:0]               unalloc_q;
    logic [31:0]              rdata;
    logic                     hit;
    logic                     wr;
    logic [7:0]               off;

    assign off = 8'(paddr);
    assign wr  = psel && penable && pready && pwrite;

    always_comb begin
        rdata = 32'h0;
        hit   = 1'b1;
        case (off)
            `DPA_NET_CTRL: rdata = {24'h0, net_q};
            `DPA_NET_STAT: rdata = {30'h0, restart_q, framing_m13_q};
            `DPA_APPLY:    rdata = {15'h0, reject_q, 6'h0, unalloc_q};
            default: begin
                hit = 1'b0;
                for (int i = 0; i < 4; i++) begin
                    if (off == `DPA_PORT_CTRL0 + 8'(4 * i)) begin
                        rdata = {6'h0, pcfg_q[i].bandwidth_block_count, 14'h0, pcfg_q[i].tr_idle, pcfg_q[i].enable};
                        hit   = 1'b1;
                    end
                    if (off == `DPA_PORT_STAT0 + 8'(4 * i)) begin
                        rdata = {6'h0, applied_q.blocks[i], 13'h0, stat_q[i]};
                        hit   = 1'b1;
                    end
                    if (off == `DPA_PORT_BW0 + 8'(4 * i)) begin
                        rdata = 32'(pcfg_q[i].bandwidth_block_count)
                              * (net_q.coarse ? `DPA_COARSE_BPS : `DPA_FINE_BPS);
                        hit   = 1'b1;
                    end
                end
            end
        endcase
        if (paddr[1:0] != 2'h0 || paddr > ADDR_W'(8'h3C)) begin
            hit = 1'b0;
        end
    end

    // Zero-wait slave: answer in the first access cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && hit && !pwrite) ? rdata : 32'h0;
        end
    end

    // ==========================================================
    // Line configuration
    logic restore, mode_chg;
    assign restore  = wr && off == `DPA_NET_CTRL && pwdata[`DPA_RESTORE_BIT];
    assign mode_chg = wr && off == `DPA_NET_CTRL && !restore && pwdata[`DPA_COARSE_BIT] != net_q.coarse;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            net_q <= dpa_net_cfg_type'(`DPA_NET_DEF);
        end else if (restore) begin
            net_q        <= dpa_net_cfg_type'(`DPA_NET_DEF);
            net_q.coarse <= net_q.coarse;
        end else if (wr && off == `DPA_NET_CTRL) begin
            net_q <= dpa_net_cfg_type'(pwdata[7:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tx_loop_timing_q <= 1'b0;
            framing_m13_q    <= 1'b0;
            dl_enable_q      <= 1'b0;
            dl_tx_bit_q      <= 1'b1;
        end else begin
            tx_loop_timing_q <= net_q.loop_timing;
            framing_m13_q    <= (net_q.framing == FR_AUTO) ? m13_s : (net_q.framing == FR_M13);
            dl_enable_q      <= net_q.data_link;
            dl_tx_bit_q      <= net_q.data_link ? mgmt_tx_bit : 1'b1;
        end
    end

    // Self-synchronous x^43+1 payload scrambler
    logic [42:0] scr_q;
    logic        scr_bit;
    assign scr_bit = payload_bit ^ scr_q[42];
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            scr_q            <= 43'h0;
            line_bit_q       <= 1'b0;
            line_bit_valid_q <= 1'b0;
        end else begin
            line_bit_valid_q <= payload_valid;
            if (payload_valid) begin
                scr_q      <= {scr_q[41:0], scr_bit};
                line_bit_q <= net_q.scramble ? scr_bit : payload_bit;
            end
        end
    end

    // ==========================================================
    // Restart on multiplexing mode change
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rs_q     <= RS_RUN;
            rs_cnt_q <= 8'h00;
        end else begin
            case (rs_q)
                RS_RUN: begin
                    if (mode_chg) begin
                        rs_q     <= RS_BOOT;
                        rs_cnt_q <= 8'(`DPA_RESTART_CYC - 1);
                    end
                end
                RS_BOOT: begin
                    if (rs_cnt_q == 8'h00) begin
                        rs_q <= RS_RUN;
                    end else begin
                        rs_cnt_q <= rs_cnt_q - 8'h01;
                    end
                end
                default: rs_q <= RS_RUN;
            endcase
        end
    end
    assign restart_q = (rs_q == RS_BOOT);

    // ==========================================================
    // Port configuration, apply and allocation check
    logic                 apply_req, from_far, alloc_ok;
    logic [3:0]           used;
    logic [3:0][9:0]      cand;
    logic [11:0]          sum_cand, sum_app;
    logic [9:0]           pool;

    assign from_far  = net_q.role == AC_SLAVE && alloc_rx_valid;
    assign apply_req = (wr && off == `DPA_APPLY && pwdata[0]) || from_far;
    assign pool      = net_q.coarse ? `DPA_COARSE_POOL : `DPA_FINE_POOL;

    always_comb begin
        alloc_ok = 1'b1;
        sum_cand = 12'h0;
        sum_app  = 12'h0;
        for (int i = 0; i < 4; i++) begin
            used[i] = inst_s[i] && pcfg_q[i].enable && !(net_q.coarse && i > 0);
            cand[i] = from_far ? alloc_rx.blocks[i] : pcfg_q[i].bandwidth_block_count;
            if (!used[i]) begin
                cand[i] = 10'h0;
            end else if (cand[i] == 10'h0 || cand[i] > (hssi_s[i] ? `DPA_HSSI_MAX : `DPA_V35_MAX)) begin
                alloc_ok = 1'b0;
            end
            sum_cand = sum_cand + 12'(cand[i]);
            sum_app  = sum_app + 12'(applied_q.blocks[i]);
        end
        if (sum_cand > 12'(pool)) begin
            alloc_ok = 1'b0;
        end
    end

    for (p = 0; p < 4; p++) begin : g_port_cfg
        always_ff @(posedge ref_clk) begin
            if (!reset_n || restore) begin
                pcfg_q[p] <= '{bandwidth_block_count: `DPA_CNT_DEF, tr_idle: 1'b0, enable: 1'b0};
            end else if (from_far && alloc_ok) begin
                pcfg_q[p].bandwidth_block_count <= alloc_rx.blocks[p];
            end else if (wr && off == `DPA_PORT_CTRL0 + 8'(4 * p)) begin
                pcfg_q[p] <= '{bandwidth_block_count: pwdata[`DPA_CNT_MSB:`DPA_CNT_LSB],
                               tr_idle: pwdata[`DPA_TR_IDLE_BIT], enable: pwdata[0]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            applied_q        <= '0;
            reject_q         <= 1'b0;
            unalloc_q        <= `DPA_FINE_POOL;
            alloc_tx_valid_q <= 1'b0;
            alloc_tx_q       <= '0;
        end else begin
            alloc_tx_valid_q <= 1'b0;
            if (apply_req) begin
                reject_q <= !alloc_ok;
                if (alloc_ok) begin
                    applied_q <= dpa_alloc_type'(cand);
                    if (net_q.role == AC_MASTER) begin
                        alloc_tx_valid_q <= 1'b1;
                        alloc_tx_q       <= dpa_alloc_type'(cand);
                    end
                end
            end
            unalloc_q <= (sum_app > 12'(pool)) ? 10'h0 : 10'(12'(pool) - sum_app);
        end
    end

    // ==========================================================
    // Port status
    for (p = 0; p < 4; p++) begin : g_port_stat
        logic shake_ok;
        assign shake_ok = hssi_s[p] ? lead_s[p] : (!pcfg_q[p].tr_idle || lead_s[p]);
        always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
                stat_q[p]      <= PS_ABSENT;
                port_pass_q[p] <= 1'b0;
            end else begin
                port_pass_q[p] <= 1'b0;
                if (!inst_s[p]) begin
                    stat_q[p] <= PS_ABSENT;
                end else if (!used[p] || restart_q) begin
                    stat_q[p] <= PS_INACTIVE;
                end else if (clk_lost[p]) begin
                    stat_q[p] <= PS_ERROR;
                end else if (!shake_ok || applied_q.blocks[p] == 10'h0) begin
                    stat_q[p] <= PS_WAITING;
                end else begin
                    stat_q[p]      <= PS_ACTIVE;
                    port_pass_q[p] <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    apb_ready_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        psel && !penable |=> pready)
        else $error("no answer in first access cycle");
    restart_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        mode_chg |=> restart_q [*8])
        else $error("mode change did not restart");
    restart_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        restart_q ##1 restart_q |=> port_pass_q == 4'h0)
        else $error("traffic during restart");
    reject_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        apply_req && sum_cand > 12'(pool) |=> reject_q && $stable(applied_q))
        else $error("overallocation accepted");
    apply_take_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        apply_req && alloc_ok |=> applied_q == $past(cand) && !reject_q)
        else $error("apply did not load counts");
    pending_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !apply_req |=> $stable(applied_q))
        else $error("counts changed without apply");
    scr_bypass_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        payload_valid && !net_q.scramble |=> line_bit_q == $past(payload_bit))
        else $error("payload altered while scrambler off");
    scr_apply_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        payload_valid && net_q.scramble |=> line_bit_q == ($past(payload_bit) ^ $past(scr_q[42])))
        else $error("payload not scrambled");
    coarse_ports_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        net_q.coarse |=> port_pass_q[3:1] == 3'h0)
        else $error("ports 2-4 pass traffic in coarse mode");
    keep_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        restore |=> $stable(net_q.coarse))
        else $error("restore changed multiplexing mode");
    clk_error_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        inst_s[0] && used[0] && !restart_q && clk_lost[0] |=> stat_q[0] == PS_ERROR)
        else $error("lost DTE clock not reported");
    hssi_wait_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        stat_q[0] == PS_ACTIVE && $past(hssi_s[0]) |-> $past(lead_s[0]))
        else $error("HSSI active without terminal available");
    cover_apply_c: cover property (@(posedge ref_clk) apply_req && alloc_ok);
    cover_reject_c: cover property (@(posedge ref_clk) apply_req && !alloc_ok);
    cover_restart_c: cover property (@(posedge ref_clk) mode_chg);
    cover_active_c: cover property (@(posedge ref_clk) stat_q[0] == PS_ACTIVE);
endmodule // dpa_allocator

//--- verification/dpa_far_model.sv
// Far side model: DTE transmit clocks, handshake leads and far-end allocation sender
`timescale 1ns/1ps
module dpa_far_model
    import dpa_pkg::*;
(
    // From the bench
    input  wire logic     ref_clk,
    input  wire logic [3:0] clk_on,
    input  wire logic [3:0] lead_on,
    input  wire logic     send,
    input  dpa_alloc_type send_blocks,
    // Toward the allocator
    output logic [3:0]    dte_tx_clk,
    output logic [3:0]    terminal_ready_lead,
    output logic          alloc_rx_valid,
    output dpa_alloc_type alloc_rx
);
    logic link_clk;
    // ==========
    // Link clock out of phase with the core; a faulty port's clock stands still
    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = ~link_clk;
    end
    assign dte_tx_clk = clk_on & {4{link_clk}};
    assign terminal_ready_lead = lead_on;
    // ==========
    // Far-end master relays its counts; idle bus toggles so stale data never looks valid
    initial begin
        alloc_rx_valid = 1'b0;
        alloc_rx = '0;
    end
    always @(posedge ref_clk) begin
        alloc_rx_valid <= send;
        if (send) begin
            alloc_rx <= send_blocks;
        end else begin
            alloc_rx <= ~alloc_rx;
        end
    end
endmodule // dpa_far_model

//--- verification/dpa_allocator_tb.sv
// Bench of the port allocator: APB register sequences against a far side model
`timescale 1ns/1ps
`include "dpa_cfg.svh"
module dpa_allocator_tb;
    import dpa_pkg::*;
    localparam logic [7:0] CT1 = `DPA_PORT_CTRL0 + 8'h04;
    localparam logic [7:0] ST1 = `DPA_PORT_STAT0 + 8'h04;
    logic          ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rv;
    logic          m13_pin, pay_bit, pay_valid, line_bit, line_valid, loop_t, fr_m13;
    logic          mgmt_bit, dl_en, dl_bit, arx_valid, atx_valid, restart, send;
    logic [3:0]    installed, tr_lead, dte_clk, pass, clk_on, lead_on;
    dpa_alloc_type arx, atx, applied, send_blocks, last_tx;
    logic          pin_bits[$], out_bits[$];
    int            n_mismatch = 0, n_tests = 0, cyc = 0, n_tx = 0;

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    dpa_allocator dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_m13_seen(m13_pin), .payload_bit(pay_bit), .payload_valid(pay_valid),
        .line_bit_q(line_bit), .line_bit_valid_q(line_valid), .tx_loop_timing_q(loop_t),
        .framing_m13_q(fr_m13), .mgmt_tx_bit(mgmt_bit), .dl_enable_q(dl_en), .dl_tx_bit_q(dl_bit),
        .alloc_rx_valid(arx_valid), .alloc_rx(arx), .alloc_tx_valid_q(atx_valid), .alloc_tx_q(atx),
        .port_installed(installed), .port_is_hssi(4'h1), .terminal_ready_lead(tr_lead),
        .dte_tx_clk(dte_clk), .port_pass_q(pass), .applied_q(applied), .restart_q(restart)
    );
    dpa_far_model far (
        .ref_clk(ref_clk), .clk_on(clk_on), .lead_on(lead_on), .send(send),
        .send_blocks(send_blocks), .dte_tx_clk(dte_clk), .terminal_ready_lead(tr_lead),
        .alloc_rx_valid(arx_valid), .alloc_rx(arx)
    );
    // ==========
    // Monitors and hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (atx_valid === 1'b1) begin
            n_tx <= n_tx + 1;
            last_tx <= atx;
        end
        if (line_valid === 1'b1) begin
            out_bits.push_back(line_bit);
        end
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // ==========
    // Tasks
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    // Request held until pready is sampled high; no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
        apb(1'b0, a, 32'h0);
        chk(w, e, rv);
    endtask
    task automatic far_send(input logic [39:0] b);
        send_blocks <= b;
        send <= 1'b1;
        @(posedge ref_clk);
        send <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    function automatic logic [31:0] pc(input int n, input logic [2:0] f);
        return (32'(n) << 16) | 32'(f);
    endfunction
    // ==========
    // Main sequence
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, m13_pin, pay_bit, pay_valid} = '0;
        {mgmt_bit, send, send_blocks, lead_on} = '0;
        installed = 4'h7;
        clk_on = 4'h7;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(`DPA_NET_CTRL, 32'h4, "net_ctrl");
        chk("loop", 32'h1, 32'(loop_t));
        rd(`DPA_PORT_CTRL0, pc(1, 0), "ctrl0");
        rd(`DPA_PORT_STAT0 + 8'h08, 32'h1, "stat2");
        rd(`DPA_PORT_STAT0 + 8'h0C, 32'h0, "stat3");
        apb(1'b0, 8'h0C, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        wr(`DPA_PORT_CTRL0, pc(588, 1));
        rd(`DPA_PORT_BW0, 588 * `DPA_FINE_BPS, "bw0");
        wr(`DPA_PORT_CTRL0, pc(448, 1));
        wr(CT1, pc(141, 3));
        wr(`DPA_APPLY, 32'h1);
        rd(`DPA_APPLY, 32'h1_0000 | 32'd588, "apply141");
        rd(`DPA_PORT_STAT0, pc(0, 3), "pending");
        wr(CT1, pc(140, 3));
        wr(`DPA_APPLY, 32'h1);
        rd(`DPA_APPLY, 32'h0, "apply588");
        rd(`DPA_PORT_STAT0, pc(448, 3), "wait_ta");
        rd(ST1, pc(140, 3), "wait_dtr");
        lead_on <= 4'h3;
        repeat (8) @(posedge ref_clk);
        rd(`DPA_PORT_STAT0, pc(448, 2), "active0");
        chk("pass", 32'h3, 32'(pass));
        wr(CT1, pc(140, 1));
        lead_on <= 4'h1;
        repeat (8) @(posedge ref_clk);
        rd(ST1, pc(140, 2), "tr_ignore");
        wr(`DPA_PORT_CTRL0, pc(449, 1));
        wr(`DPA_APPLY, 32'h1);
        rd(`DPA_APPLY, 32'h1_0000, "apply589");
        chk("kept", 32'd448, 32'(applied.blocks[0]));
        wr(`DPA_PORT_CTRL0, pc(448, 1));
        clk_on <= 4'h6;
        repeat (230) @(posedge ref_clk);
        rd(`DPA_PORT_STAT0, pc(448, 6), "clk_loss");
        clk_on <= 4'h7;
        wr(`DPA_NET_CTRL, 32'h44);
        wr(`DPA_APPLY, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("tx_count", 32'h1, 32'(n_tx));
        chk("tx_port1", 32'd140, 32'(last_tx.blocks[1]));
        chk("tx_port0", 32'd448, 32'(last_tx.blocks[0]));
        wr(`DPA_NET_CTRL, 32'h84);
        far_send({10'd0, 10'd0, 10'd40, 10'd300});
        chk("slave", 32'd300, 32'(applied.blocks[0]));
        rd(`DPA_PORT_CTRL0, pc(300, 1), "slave_pend");
        wr(`DPA_NET_CTRL, 32'h04);
        far_send({10'd0, 10'd0, 10'd50, 10'd60});
        chk("role_off", 32'd300, 32'(applied.blocks[0]));
        m13_pin <= 1'b1;
        mgmt_bit <= 1'b0;
        wr(`DPA_NET_CTRL, 32'h26);
        repeat (6) @(posedge ref_clk);
        rd(`DPA_NET_STAT, 32'h1, "auto_m13");
        chk("dl", 32'h2, {30'h0, dl_en, dl_bit});
        m13_pin <= 1'b0;
        wr(`DPA_NET_CTRL, 32'h01);
        repeat (6) @(posedge ref_clk);
        chk("m13", 32'h1, 32'(fr_m13));
        chk("local", 32'h0, 32'(loop_t));
        chk("dl_idle", 32'h1, {30'h0, dl_en, dl_bit});
        for (int s = 0; s < 2; s++) begin
            wr(`DPA_NET_CTRL, (s == 1) ? 32'h8 : 32'h0);
            pin_bits.delete();
            out_bits.delete();
            for (int k = 0; k < 100; k++) begin
                pay_bit <= k[0] ^ k[3] ^ k[5];
                pay_valid <= 1'b1;
                pin_bits.push_back(k[0] ^ k[3] ^ k[5]);
                @(posedge ref_clk);
            end
            pay_valid <= 1'b0;
            repeat (3) @(posedge ref_clk);
            for (int k = 43; k < 100; k++) begin
                chk("line", 32'(pin_bits[k] ^ (s == 1 && out_bits[k - 43])), 32'(out_bits[k]));
            end
        end
        wr(`DPA_NET_CTRL, 32'h14);
        rd(`DPA_NET_STAT, 32'h2, "restart");
        chk("pass_boot", 32'h0, 32'(pass));
        chk("restart_pin", 32'h1, 32'(restart));
        repeat (210) @(posedge ref_clk);
        chk("restart_end", 32'h0, 32'(restart));
        wr(`DPA_NET_CTRL, 32'h100);
        rd(`DPA_NET_CTRL, 32'h14, "restore");
        wr(`DPA_PORT_CTRL0, pc(15, 1));
        wr(`DPA_APPLY, 32'h1);
        apb(1'b0, `DPA_APPLY, 32'h0);
        chk("coarse15", 32'h1, 32'(rv[16]));
        wr(`DPA_PORT_CTRL0, pc(14, 1));
        wr(`DPA_APPLY, 32'h1);
        rd(`DPA_APPLY, 32'h0, "coarse14");
        rd(ST1, 32'h1, "port1_off");
        rd(`DPA_PORT_BW0, 14 * `DPA_COARSE_BPS, "bw_coarse");
        complete_run();
    end
endmodule // dpa_allocator_tb
